// ===== design/dwc_pkg.sv
// Summary of operation
// - Opcode CAh starts 28-bit DMA write.
// - 28-bit count 00h means 256 sectors.
// - Low/mid bytes give address bits 15:0.
// - High byte gives cylinder high or bits 23:16.
// - Select bit 6 picks logical or CHS.
// - Select bits 3:0 give head or 27:24.
// - Success clears busy/fault/request/error, sets ready.
// - Fatal error ends command, loads failing address.
// - Error bit 7 flags Ultra DMA CRC.
// - Write-protect and media-changed bits, clear change flag.
// - ID-not-found for missing or out-of-range address.
// - Media-change-request bit sticks until media access.
// - Abort for unsupported, Ultra DMA error, range.
// - No-media bit when media absent.
// - Error end: ready, fault if any, error summary.
// - Opcode 35h starts 48-bit DMA write.
// - Packet-capable device refuses the extended write.
// - Feature, count and address registers keep current and previous bytes.
// - Extended count 16 bits, 0000h means 65536.
// - Extended address assembled from current/previous bytes.
// - High-order select bit reads previous bytes.
`default_nettype none
package dwc_pkg;
	localparam logic [7:0] DWC_OP_WR28 = 8'hCA;
	localparam logic [7:0] DWC_OP_WR48 = 8'h35;
	// APB byte addresses of the register file.
	localparam logic [7:0] DWC_A_FEAT = 8'h00;
	localparam logic [7:0] DWC_A_CNT = 8'h04;
	localparam logic [7:0] DWC_A_ALO = 8'h08;
	localparam logic [7:0] DWC_A_AMID = 8'h0C;
	localparam logic [7:0] DWC_A_AHI = 8'h10;
	localparam logic [7:0] DWC_A_DSEL = 8'h14;
	localparam logic [7:0] DWC_A_CMD = 8'h18;
	localparam logic [7:0] DWC_A_ERR = 8'h1C;
	localparam logic [7:0] DWC_A_STAT = 8'h20;
	localparam logic [7:0] DWC_A_CTRL = 8'h24;
	localparam logic [7:0] DWC_A_XFER = 8'h28;
	localparam logic [7:0] DWC_A_LBAL = 8'h2C;
	localparam logic [7:0] DWC_A_LBAH = 8'h30;
	// Control register fields.
	localparam int DWC_CTRL_HOB = 7;
	// Status register fields.
	localparam int DWC_ST_BSY = 7;
	localparam int DWC_ST_DRDY = 6;
	localparam int DWC_ST_DF = 5;
	localparam int DWC_ST_DRQ = 3;
	localparam int DWC_ST_ERR = 0;
	// Error register fields.
	localparam int DWC_ER_ICRC = 7;
	localparam int DWC_ER_WP = 6;
	localparam int DWC_ER_MC = 5;
	localparam int DWC_ER_IDNF = 4;
	localparam int DWC_ER_MCR = 3;
	localparam int DWC_ER_ABRT = 2;
	localparam int DWC_ER_NM = 1;
	// Device/head fields.
	localparam int DWC_DH_LBA = 6;
	localparam int DWC_DH_DEV = 4;
	localparam logic [7:0] DWC_STAT_RST = 8'h40;
	localparam logic [16:0] DWC_CNT28_ZERO = 17'h00100;
	localparam logic [16:0] DWC_CNT48_ZERO = 17'h10000;
	typedef enum logic [2:0] {DWC_IDLE, DWC_XFER, DWC_DONE, DWC_FAIL}
		dwc_state_t;
endpackage
`default_nettype wire

// ===== design/dwc_taskreg.sv
`timescale 1ns/10ps
`default_nettype none
// One command block byte with current and previous copies.
module dwc_taskreg (
	input wire logic clk_sys, // System clock.
	input wire logic sys_rst, // Synchronous reset.
	input wire logic host_we, // Host write strobe.
	input wire logic [7:0] host_d, // Host write byte.
	input wire logic dev_we, // Device load strobe.
	input wire logic [7:0] dev_cur, // Device current byte.
	input wire logic [7:0] dev_prev, // Device previous byte.
	output logic [7:0] cur_q, // Most recent byte.
	output logic [7:0] prev_q // Byte before it.
);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur_q <= 8'h00;
			prev_q <= 8'h00;
		end else if (dev_we) begin
			cur_q <= dev_cur;
			prev_q <= dev_prev;
		end else if (host_we) begin
			cur_q <= host_d;
			prev_q <= cur_q;
		end
	end
endmodule // dwc_taskreg
`default_nettype wire

// ===== design/dwc_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for a bundle of pin levels.
module dwc_sync #(
	parameter int W = 8
) (
	input wire logic clk_sys, // System clock.
	input wire logic sys_rst, // Synchronous reset.
	input wire logic [W-1:0] d, // Asynchronous levels.
	output logic [W-1:0] q // Synchronised levels.
);
	logic [W-1:0] meta_r;
	if (W < 1) begin : g_bad_w
		$error("W must be positive");
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // dwc_sync
`default_nettype wire

// ===== design/dwc_top.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Device-side handler for the 28-bit and 48-bit DMA write commands.
module dwc_top import dwc_pkg::*; #(
	parameter bit PACKET_SET = 1'b0
) (
	input wire logic clk_sys, // System clock.
	input wire logic sys_rst, // Synchronous reset.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB byte strobes.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error.
	input wire logic media_absent, // Pin: no media present.
	input wire logic media_protect, // Pin: media write protected.
	input wire logic media_changed, // Pin: media change seen.
	input wire logic media_change_req, // Pin: eject request.
	input wire logic xfer_udma, // Transfer runs as Ultra DMA.
	input wire logic xfer_done, // Pulse: all data moved.
	input wire logic xfer_crc_err, // Pulse: Ultra DMA CRC error.
	input wire logic xfer_udma_err, // Pulse: other Ultra DMA error.
	input wire logic xfer_fatal, // Pulse: unrecoverable error.
	input wire logic [47:0] xfer_fail_lba, // Failing sector address.
	input wire logic addr_bad, // Address out of range.
	input wire logic addr_idnf, // Report range as ID-not-found.
	input wire logic geom_invalid, // No valid translation yet.
	input wire logic dev_fault, // Device fault level.
	output logic xfer_start, // Pulse: begin DMA write.
	output logic [47:0] xfer_lba, // Start address or CHS.
	output logic xfer_chs, // Address is CHS.
	output logic [16:0] xfer_count, // Sectors to move.
	output logic dma_req // Data request level.
);
	logic [3:0] pin_s;
	logic [7:0] cur [6];
	logic [7:0] prv [6];
	logic [7:0] dsel_r, err_r, ctrl_r, stat_r, prdata_r;
	logic [47:0] lba_r;
	logic chs_r, start_r, mc_pend_r, mcr_r, pready_r, pslverr_r;
	logic [16:0] cnt_r;
	dwc_state_t st_r, st_nxt;

	dwc_sync #(.W(4)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d({media_absent, media_protect, media_changed, media_change_req}),
		.q(pin_s)
	);
	wire nm_s = pin_s[3];
	wire wp_s = pin_s[2];
	wire mc_s = pin_s[1];
	wire mcr_s = pin_s[0];

	// One-wait APB: access phase completes in its second cycle.
	wire acc = psel && penable && !pready_r;
	wire wr = acc && pwrite && pstrb[0];
	wire busy = stat_r[DWC_ST_BSY];
	wire hit_rw = paddr <= DWC_A_LBAH && paddr[1:0] == 2'b00;
	wire hob = ctrl_r[DWC_CTRL_HOB];
	wire [7:0] wd = pwdata[7:0];
	wire wr_cmd = wr && paddr == DWC_A_CMD && !busy;
	wire wr_ctrl = wr && paddr == DWC_A_CTRL;
	wire wr_dsel = wr && paddr == DWC_A_DSEL && !busy;
	wire is28 = wd == DWC_OP_WR28 && !PACKET_SET;
	wire is48 = wd == DWC_OP_WR48 && !PACKET_SET;
	wire fail_load = st_r == DWC_XFER && xfer_fatal;

	// Indices 0..4: feature, count, low, mid, high.
	wire [47:0] lba_f = fail_load ? xfer_fail_lba : 48'h0;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_reg
			// Offsets kept in range for the bytes that never load.
			localparam int LO = gi >= 2 ? (gi - 2) * 8 : 0;
			localparam int HI = gi >= 2 ? (gi + 1) * 8 : 0;
			wire [7:0] a = 8'(gi * 4);
			wire hw = wr && paddr == a && !busy;
			wire dw = fail_load && gi >= 2;
			wire [7:0] dc = gi >= 2 ? lba_f[LO +: 8] : 8'h00;
			wire [7:0] dp = gi >= 2 ? lba_f[HI +: 8] : 8'h00;
			dwc_taskreg u_reg (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.host_we(hw),
				.host_d(wd),
				.dev_we(dw),
				.dev_cur(dc),
				.dev_prev(dp),
				.cur_q(cur[gi]),
				.prev_q(prv[gi])
			);
		end
	endgenerate
	assign cur[5] = 8'h00;
	assign prv[5] = 8'h00;

	// Start address and count for each command form.
	wire lba_mode = dsel_r[DWC_DH_LBA];
	wire [47:0] a28 = {20'h00000, dsel_r[3:0], cur[4], cur[3], cur[2]};
	wire [47:0] a48 = {prv[4], prv[3], prv[2], cur[4], cur[3], cur[2]};
	wire [15:0] c48 = {prv[1], cur[1]};
	wire [16:0] n28 = cur[1] == 8'h00 ? DWC_CNT28_ZERO : {9'h000, cur[1]};
	wire [16:0] n48 = c48 == 16'h0000 ? DWC_CNT48_ZERO : {1'b0, c48};

	// Error flags gathered at command write and during the transfer.
	wire abrt_rng = addr_bad && !addr_idnf;
	wire idnf = geom_invalid || (addr_bad && addr_idnf);
	wire [7:0] err_start = {1'b0, wp_s, mc_pend_r, idnf, mcr_r, abrt_rng,
		nm_s, 1'b0};
	wire start_ok = err_start == 8'h00;
	wire [7:0] err_x = {xfer_crc_err && xfer_udma, 7'h00};
	wire abrt_x = xfer_udma && (xfer_crc_err || xfer_udma_err);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			DWC_IDLE:
				if (wr_cmd && (is28 || is48) && start_ok)
					st_nxt = DWC_XFER;
				else if (wr_cmd)
					st_nxt = DWC_FAIL;
			DWC_XFER:
				if (xfer_fatal || abrt_x || xfer_crc_err)
					st_nxt = DWC_FAIL;
				else if (xfer_done)
					st_nxt = DWC_DONE;
			DWC_DONE: st_nxt = DWC_IDLE;
			DWC_FAIL: st_nxt = DWC_IDLE;
			default: st_nxt = DWC_IDLE;
		endcase
	end

	// Status: busy from acceptance until posting.
	wire [7:0] stat_nxt =
		st_nxt == DWC_XFER ? 8'h80 | (stat_r & 8'h10) :
		st_nxt == DWC_FAIL ? 8'h80 :
		st_r == DWC_DONE ? 8'h40 :
		st_r == DWC_FAIL ? {1'b0, 1'b1, dev_fault, 4'h0,
			err_r != 8'h00} : stat_r;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= DWC_IDLE;
			stat_r <= DWC_STAT_RST;
		end else begin
			st_r <= st_nxt;
			stat_r <= stat_nxt;
		end
	end

	// Media-change latch: set wins over the clear at command time.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mc_pend_r <= 1'b0;
			mcr_r <= 1'b0;
		end else begin
			mc_pend_r <= mc_s || (mc_pend_r && !wr_cmd);
			mcr_r <= mcr_s || (mcr_r && !(st_r == DWC_DONE));
		end
	end

	wire [7:0] err_nxt =
		wr_cmd && !(is28 || is48) ? 8'h04 :
		wr_cmd ? err_start :
		st_r == DWC_XFER ? err_r | err_x | {5'h00, abrt_x, 2'b00} :
		err_r;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			err_r <= 8'h00;
			dsel_r <= 8'h00;
			ctrl_r <= 8'h00;
		end else begin
			err_r <= err_nxt;
			if (fail_load)
				dsel_r <= {dsel_r[7:4], xfer_fail_lba[27:24]};
			else if (wr_dsel)
				dsel_r <= wd;
			if (wr_ctrl)
				ctrl_r <= wd;
		end
	end

	// Latched command parameters toward the DMA engine.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lba_r <= 48'h0;
			chs_r <= 1'b0;
			cnt_r <= 17'h0;
			start_r <= 1'b0;
		end else begin
			start_r <= st_r == DWC_IDLE && st_nxt == DWC_XFER;
			if (st_r == DWC_IDLE && st_nxt == DWC_XFER) begin
				lba_r <= is48 ? a48 : a28;
				chs_r <= !is48 && !lba_mode;
				cnt_r <= is48 ? n48 : n28;
			end
		end
	end

	// Read mux; the high-order select returns previous bytes.
	wire [2:0] ridx = paddr[4:2] > 3'd4 ? 3'd5 : paddr[4:2];
	wire [7:0] rbyte = hob ? prv[ridx] : cur[ridx];
	wire [7:0] rdat =
		paddr == DWC_A_DSEL ? dsel_r :
		paddr == DWC_A_ERR ? err_r :
		paddr == DWC_A_STAT ? stat_r :
		paddr == DWC_A_CTRL ? ctrl_r :
		paddr == DWC_A_XFER ? cnt_r[7:0] :
		paddr == DWC_A_LBAL ? lba_r[7:0] :
		paddr == DWC_A_LBAH ? lba_r[47:40] :
		paddr <= DWC_A_AHI && paddr != DWC_A_FEAT ? rbyte : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 8'h00;
		end else begin
			pready_r <= psel && penable && !pready_r;
			pslverr_r <= acc && !hit_rw;
			prdata_r <= acc && !pwrite ? rdat : 8'h00;
		end
	end

	assign prdata = {24'h000000, prdata_r};
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign xfer_start = start_r;
	assign xfer_lba = lba_r;
	assign xfer_chs = chs_r;
	assign xfer_count = cnt_r;
	assign dma_req = 1'b0;
endmodule // dwc_top
`default_nettype wire

// ===== sim/dwc_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dwc_top_chk import dwc_pkg::*; #(
	parameter bit PACKET_SET = 1'b0
) (
	input wire logic clk_sys, // Clock.
	input wire logic sys_rst, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pwrite, // Direction.
	input wire logic [7:0] paddr, // Address.
	input wire logic [31:0] pwdata, // Write data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic xfer_start, // Start pulse.
	input wire logic [47:0] xfer_lba, // Address.
	input wire logic [16:0] xfer_count, // Count.
	input wire logic dma_req // Request.
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	logic cmd_w;
	assign cmd_w = psel && penable && pwrite && paddr == DWC_A_CMD
		&& (pwdata[7:0] == DWC_OP_WR28 || pwdata[7:0] == DWC_OP_WR48);
	property p_cmd; xfer_start |-> $past(cmd_w, 1); endproperty
	a_cmd: assert property (p_cmd) else $error("start without command");
	property p_pulse; xfer_start |=> !xfer_start; endproperty
	a_pulse: assert property (p_pulse) else $error("start too long");
	property p_cnt; xfer_start |-> xfer_count != 17'h0
		&& xfer_count <= DWC_CNT48_ZERO; endproperty
	a_cnt: assert property (p_cnt) else $error("bad count");
	property p_drq; !dma_req; endproperty
	a_drq: assert property (p_drq) else $error("request raised");
	property p_pkt; !(PACKET_SET && xfer_start); endproperty
	a_pkt: assert property (p_pkt) else $error("start on packet part");
	property p_hold; xfer_start |=> $stable(xfer_lba) && $stable(xfer_count);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved");
	property p_rdy; psel && penable && !pready |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_err; pslverr |-> pready && (paddr > DWC_A_LBAH
		|| paddr[1:0] != 2'b00); endproperty
	a_err: assert property (p_err) else $error("bad slave error");
endmodule // dwc_top_chk
bind dwc_top dwc_top_chk #(.PACKET_SET(PACKET_SET)) u_chk (.clk_sys,
	.sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.xfer_start, .xfer_lba, .xfer_count, .dma_req);
`default_nettype wire

// ===== sim/dwc_xfer_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far end of the channel: ends each transfer after a chosen lag.
module dwc_xfer_model (
	input wire logic clk_sys, // Clock.
	input wire logic sys_rst, // Reset.
	input wire logic xfer_start, // Transfer begins.
	input wire logic [1:0] mode, // Done, CRC, other error, fatal.
	input wire logic [3:0] lag, // Cycles before the end.
	input wire logic [47:0] seed_lba, // Address told on fatal.
	output logic xfer_done, // Done pulse.
	output logic xfer_crc_err, // CRC pulse.
	output logic xfer_udma_err, // Error pulse.
	output logic xfer_fatal, // Fatal pulse.
	output logic [47:0] xfer_fail_lba // Failing address.
);
	logic [4:0] cnt_r;
	always_ff @(posedge clk_sys) begin
		{xfer_done, xfer_crc_err, xfer_udma_err, xfer_fatal} <= 4'h0;
		xfer_fail_lba <= ~seed_lba;
		if (sys_rst)
			cnt_r <= 5'h00;
		else if (xfer_start)
			cnt_r <= {1'b0, lag} + 5'h01;
		else if (cnt_r != 5'h00) begin
			cnt_r <= cnt_r - 5'h01;
			if (cnt_r == 5'h01) begin
				xfer_done <= mode == 2'h0;
				xfer_crc_err <= mode == 2'h1;
				xfer_udma_err <= mode == 2'h2;
				xfer_fatal <= mode == 2'h3;
				xfer_fail_lba <= seed_lba;
			end
		end
	end
endmodule // dwc_xfer_model
`default_nettype wire

// ===== sim/dwc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dwc_top_bench import dwc_pkg::*;;
	localparam logic [6:0] PINS [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h18,
		7'h20, 7'h40};
	localparam logic [7:0] ERRS [7] = '{8'h40, 8'h02, 8'h10, 8'h04, 8'h10,
		8'h20, 8'h08};
	logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, xfer_udma = 1'b0, dev_fault = 1'b0, err;
	logic pready, pslverr, xfer_start, xfer_chs, dma_req, dn, ce, ue, fa, s_chs;
	logic [6:0] pin = 7'h00;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [1:0] mode = 2'h0;
	logic [3:0] lag = 4'h0;
	logic [47:0] xfer_lba, fail_lba, rd, st, s_lba, seed_lba = 48'h0;
	logic [16:0] xfer_count, s_cnt;
	int num_errors = 0, checks = 0, starts = 0, seed = 32'hba44d5db;
	int cur[5], prv[5];
	initial forever #5 clk_sys = ~clk_sys;
	dwc_top uut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
		.media_absent(pin[1]), .media_protect(pin[0]), .media_changed(pin[5]),
		.media_change_req(pin[6]), .xfer_udma, .xfer_done(dn),
		.xfer_crc_err(ce), .xfer_udma_err(ue), .xfer_fatal(fa),
		.xfer_fail_lba(fail_lba), .addr_bad(pin[3]), .addr_idnf(pin[4]),
		.geom_invalid(pin[2]), .dev_fault, .xfer_start, .xfer_lba, .xfer_chs,
		.xfer_count, .dma_req);
	dwc_xfer_model far (.clk_sys, .sys_rst, .xfer_start, .mode, .lag,
		.seed_lba, .xfer_done(dn), .xfer_crc_err(ce), .xfer_udma_err(ue),
		.xfer_fatal(fa), .xfer_fail_lba(fail_lba));
	always @(posedge clk_sys) if (xfer_start === 1'b1) begin
		starts++;
		s_lba = xfer_lba;
		s_cnt = xfer_count;
		s_chs = xfer_chs;
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		rd = 48'(prdata);
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Each task byte write moves the old byte to the previous copy.
	task automatic wreg(input int i, input logic [7:0] d);
		prv[i] = cur[i];
		cur[i] = d;
		apb(1'b1, 8'(4 * i + 4), d);
	endtask
	task automatic cmd(input logic [7:0] op);
		lag <= 4'($random(seed));
		apb(1'b1, DWC_A_CMD, op);
		do begin
			apb(1'b0, DWC_A_STAT, 0);
		end while (rd[DWC_ST_BSY] !== 1'b0);
		st = rd;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		$display("Error %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, DWC_A_STAT, 0);
		chk(rd, 48'(DWC_STAT_RST));
		for (int m = 0; m < 2; m++) begin
			wreg(0, m ? 8'($random(seed)) : 8'h00);
			for (int i = 1; i < 4; i++) wreg(i, 8'($random(seed)));
			wreg(4, 8'(160 + 64 * m + ($random(seed) & 31)));
			cmd(DWC_OP_WR28);
			chk(48'(s_cnt), cur[0] == 0 ? 48'd256 : 48'(cur[0]));
			chk(48'(s_chs), 48'(1 - m));
			chk(s_lba, {20'h0, 4'(cur[4]), 8'(cur[3]), 8'(cur[2]),
				8'(cur[1])});
			chk(st, 48'h40);
		end
		$display("test short form done");
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 8; i++) wreg(i / 2, m ? 8'($random(seed)) : 8'h0);
			wreg(4, 8'h40);
			apb(1'b1, DWC_A_CTRL, 128);
			apb(1'b0, DWC_A_ALO, 0);
			chk(rd, 48'(prv[1]));
			apb(1'b1, DWC_A_CTRL, 0);
			apb(1'b0, DWC_A_ALO, 0);
			chk(rd, 48'(cur[1]));
			cmd(DWC_OP_WR48);
			chk(48'(s_cnt), prv[0] + cur[0] == 0 ? 48'h10000
				: 48'(prv[0] * 256 + cur[0]));
			chk(s_lba, {8'(prv[3]), 8'(prv[2]), 8'(prv[1]), 8'(cur[3]),
				8'(cur[2]), 8'(cur[1])});
			chk(st, 48'h40);
		end
		$display("test extended form done");
		for (int m = 1; m < 4; m++) begin
			mode <= 2'(m);
			xfer_udma <= 1'b1;
			dev_fault <= m == 3;
			seed_lba <= 48'($random(seed));
			cmd(DWC_OP_WR28);
			apb(1'b0, DWC_A_ERR, 0);
			chk(st, 48'h40 | (m == 3 ? 48'h20 : 48'h0) | 48'(rd != 0));
			chk(rd, m == 1 ? 48'h84 : m == 2 ? 48'h04 : 48'h00);
			for (int i = 1; m == 3 && i < 4; i++) begin
				apb(1'b0, 8'(4 * i + 4), 0);
				chk(rd, 48'(seed_lba[8 * i - 8 +: 8]));
			end
			if (m == 3) begin
				apb(1'b0, DWC_A_DSEL, 0);
				chk(rd, 48'({4'(cur[4] >> 4), seed_lba[27:24]}));
			end
		end
		mode <= 2'h0;
		dev_fault <= 1'b0;
		$display("test transfer errors done");
		cmd(8'h20);
		apb(1'b0, DWC_A_ERR, 0);
		chk(rd, 48'h04);
		for (int i = 0; i < 7; i++) begin
			pin <= PINS[i];
			repeat (4) @(posedge clk_sys);
			// A media change is an event: the latch must outlive the pin.
			pin <= PINS[i] & 7'h5F;
			repeat (3) @(posedge clk_sys);
			cmd(DWC_OP_WR28);
			pin <= 7'h00;
			apb(1'b0, DWC_A_ERR, 0);
			chk(rd, 48'(ERRS[i]));
			chk(st, 48'h41);
		end
		chk(48'(starts), 48'd7);
		apb(1'b0, 8'h34, 0);
		chk(48'(err), 48'h1);
		apb(1'b0, 8'h05, 0);
		chk(48'(err), 48'h1);
		$display("test refusals done");
		complete_run();
	end
endmodule // dwc_top_bench
`default_nettype wire
